// File: verilog/store_recall_regs.svh
// constants of the two-wire slave front end with store/recall sequencer
// assumes mclk at 10 MHz; link-side sampling clock runs much faster than scl
//
// Overview of operation
// - backup only when array written since last backup/restore
// - supply falling below trip starts backup
// - backup keeps device busy through store and recall
// - supply back during backup: finish, then restore
// - supply rising above trip starts timed restore
// - supply lost in restore: abandon, no backup
// - no acknowledge while backup or restore runs
// - supply below trip: ignore traffic, never acknowledge
// - reconnect main supply after backup and main above cap
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - sda change during scl high is never data
// - one bit per scl pulse, change while low
// - receiver acknowledges each byte on ninth pulse
// - acknowledge holds sda low through ninth high phase
// - master nack ends read, slave releases sda
// - acknowledge good control byte and following bytes
// - wrong control byte: acknowledge nothing afterwards
// - control byte is 1010, selects, one, direction
// - respond only when select bits equal select pins
// - direction bit one reads, zero writes
`ifndef STORE_RECALL_REGS_SVH
`define STORE_RECALL_REGS_SVH

`define MCLK_MHZ            10
`define STORE_DURATION_US   10000
`define RECALL_DURATION_US  550
`define STORE_CYCLES        (`STORE_DURATION_US * `MCLK_MHZ)
`define RECALL_CYCLES       (`RECALL_DURATION_US * `MCLK_MHZ)

`define CTRL_OPCODE         4'ha
`define CTRL_OPCODE_MSB     7
`define CTRL_OPCODE_LSB     4
`define CTRL_SEL_HIGH_BIT   3
`define CTRL_SEL_LOW_BIT    2
`define CTRL_FIXED_BIT      1
`define CTRL_DIR_BIT        0
`define ADDR_BYTES          2

`endif

// File: verilog/store_recall_pkg.sv
// types shared by the slave front end and its power-event sequencer
// assumes nothing of its surroundings
package store_recall_pkg;

    typedef enum logic [1:0] {
        SEQ_DOWN,
        SEQ_READY,
        SEQ_STORE,
        SEQ_RECALL
    } seq_state_type;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_RX,
        BUS_ACK,
        BUS_TX,
        BUS_MACK,
        BUS_IGNORE
    } bus_state_type;

    typedef struct packed {
        logic       valid;
        logic       is_data;
        logic [7:0] data;
    } rx_byte_type;

endpackage

// File: verilog/power_event_seq.sv
// power-event sequencer: automatic backup and restore with busy timing
// assumes synchronised level inputs on mclk and a one-cycle write pulse
`timescale 1ns/100ps
`include "store_recall_regs.svh"
module power_event_seq import store_recall_pkg::*; #(
    parameter int STORE_CYCLES  = `STORE_CYCLES,
    parameter int RECALL_CYCLES = `RECALL_CYCLES
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          trip_above,
    input  wire logic          main_above_cap,
    input  wire logic          array_written,
    output seq_state_type      state,
    output logic               busy,
    output logic               vcc_connect
);

    seq_state_type state_reg;
    logic [31:0]   count_reg;
    logic          trip_prev_reg;
    logic          modified_reg;
    logic          rise;
    logic          fall;

    assign rise  = trip_above & ~trip_prev_reg;
    assign fall  = ~trip_above & trip_prev_reg;
    assign state = state_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trip_prev_reg <= 1'b0;
        end else begin
            trip_prev_reg <= trip_above;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= SEQ_DOWN;
            count_reg <= 32'h0;
        end else begin
            case (state_reg)
                SEQ_DOWN: begin
                    if (rise) begin
                        state_reg <= SEQ_RECALL;
                        count_reg <= 32'h0;
                    end
                end
                SEQ_READY: begin
                    if (fall) begin
                        count_reg <= 32'h0;
                        if (modified_reg) begin
                            state_reg <= SEQ_STORE;
                        end else begin
                            state_reg <= SEQ_DOWN;
                        end
                    end
                end
                SEQ_STORE: begin
                    if (count_reg == STORE_CYCLES - 1) begin
                        count_reg <= 32'h0;
                        if (trip_above) begin
                            state_reg <= SEQ_RECALL;
                        end else begin
                            state_reg <= SEQ_DOWN;
                        end
                    end else begin
                        count_reg <= count_reg + 32'h1;
                    end
                end
                SEQ_RECALL: begin
                    if (fall) begin
                        state_reg <= SEQ_DOWN;
                    end else if (count_reg == RECALL_CYCLES - 1) begin
                        state_reg <= SEQ_READY;
                    end else begin
                        count_reg <= count_reg + 32'h1;
                    end
                end
                default: begin
                    state_reg <= SEQ_DOWN;
                end
            endcase
        end
    end

    // written since last backup or restore; a write in the clearing cycle wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modified_reg <= 1'b0;
        end else if (array_written) begin
            modified_reg <= 1'b1;
        end else if (state_reg == SEQ_STORE || state_reg == SEQ_RECALL) begin
            modified_reg <= 1'b0;
        end
    end

    // ready only when the supply is above trip and no transfer runs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy <= 1'b1;
        end else begin
            busy <= (state_reg != SEQ_READY) || fall;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vcc_connect <= 1'b0;
        end else if (fall) begin
            vcc_connect <= 1'b0;
        end else if (main_above_cap && state_reg != SEQ_STORE) begin
            vcc_connect <= 1'b1;
        end
    end

endmodule

// File: verilog/two_wire_store_slave.sv
// two-wire serial slave front end with automatic backup/restore control
// assumes lclk is a free-running sampling clock far faster than scl,
// unrelated to mclk; scl, sda and the comparators come from pins
`timescale 1ns/100ps
`include "store_recall_regs.svh"
module two_wire_store_slave import store_recall_pkg::*; #(
    parameter int STORE_CYCLES  = `STORE_CYCLES,
    parameter int RECALL_CYCLES = `RECALL_CYCLES
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          lclk,
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe,
    input  wire logic          chip_select_pin_low,
    input  wire logic          chip_select_pin_high,
    input  wire logic          trip_above_i,
    input  wire logic          main_above_cap_i,
    input  wire logic [7:0]    rd_data,
    output logic               rd_next,
    output rx_byte_type        rx_byte,
    output logic               busy,
    output logic               vcc_connect
);

    // ****************************************
    // mclk side: pin synchronisers and sequencer
    // ****************************************
    logic          trip_meta_reg;
    logic          trip_sync_reg;
    logic          main_meta_reg;
    logic          main_sync_reg;
    logic          wr_meta_reg;
    logic          wr_sync_reg;
    logic          wr_prev_reg;
    logic          wr_toggle_reg;
    logic          array_written;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trip_meta_reg <= 1'b0;
            trip_sync_reg <= 1'b0;
            main_meta_reg <= 1'b0;
            main_sync_reg <= 1'b0;
        end else begin
            trip_meta_reg <= trip_above_i;
            trip_sync_reg <= trip_meta_reg;
            main_meta_reg <= main_above_cap_i;
            main_sync_reg <= main_meta_reg;
        end
    end

    // write events arrive as toggles from the link side
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_meta_reg <= 1'b0;
            wr_sync_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
        end else begin
            wr_meta_reg <= wr_toggle_reg;
            wr_sync_reg <= wr_meta_reg;
            wr_prev_reg <= wr_sync_reg;
        end
    end

    assign array_written = wr_sync_reg ^ wr_prev_reg;

    power_event_seq #(
        .STORE_CYCLES  (STORE_CYCLES),
        .RECALL_CYCLES (RECALL_CYCLES)
    ) u_seq (
        .mclk           (mclk),
        .rst            (rst),
        .trip_above     (trip_sync_reg),
        .main_above_cap (main_sync_reg),
        .array_written  (array_written),
        .state          (),
        .busy           (busy),
        .vcc_connect    (vcc_connect)
    );

    // ****************************************
    // link side: input synchronisers
    // ****************************************
    logic          scl_meta_reg;
    logic          scl_sync_reg;
    logic          scl_prev_reg;
    logic          sda_meta_reg;
    logic          sda_sync_reg;
    logic          sda_prev_reg;
    logic          busy_meta_reg;
    logic          busy_sync_reg;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_cond;
    logic          stop_cond;

    always_ff @(posedge lclk or posedge rst) begin
        if (rst) begin
            scl_meta_reg  <= 1'b1;
            scl_sync_reg  <= 1'b1;
            scl_prev_reg  <= 1'b1;
            sda_meta_reg  <= 1'b1;
            sda_sync_reg  <= 1'b1;
            sda_prev_reg  <= 1'b1;
            busy_meta_reg <= 1'b1;
            busy_sync_reg <= 1'b1;
        end else begin
            scl_meta_reg  <= scl_i;
            scl_sync_reg  <= scl_meta_reg;
            scl_prev_reg  <= scl_sync_reg;
            sda_meta_reg  <= sda_i;
            sda_sync_reg  <= sda_meta_reg;
            sda_prev_reg  <= sda_sync_reg;
            busy_meta_reg <= busy;
            busy_sync_reg <= busy_meta_reg;
        end
    end

    assign scl_rise   = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall   = ~scl_sync_reg & scl_prev_reg;
    // sda moving under a steady high scl is a condition, not data
    assign start_cond = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
    assign stop_cond  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

    // ****************************************
    // control byte check
    // ****************************************
    function automatic logic ctrl_match(input logic [7:0] b,
                                        input logic       sel_high,
                                        input logic       sel_low);
        ctrl_match = (b[`CTRL_OPCODE_MSB:`CTRL_OPCODE_LSB] == `CTRL_OPCODE)
                   && (b[`CTRL_SEL_HIGH_BIT] == sel_high)
                   && (b[`CTRL_SEL_LOW_BIT] == sel_low)
                   && b[`CTRL_FIXED_BIT];
    endfunction

    // ****************************************
    // link side: bus state machine
    // ****************************************
    bus_state_type bus_state_reg;
    logic [3:0]    bit_cnt_reg;
    logic [7:0]    shift_reg;
    logic [1:0]    byte_idx_reg;
    logic          read_mode_reg;

    always_ff @(posedge lclk or posedge rst) begin
        if (rst) begin
            bus_state_reg <= BUS_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            byte_idx_reg  <= 2'h0;
            read_mode_reg <= 1'b0;
            sda_oe        <= 1'b0;
            rd_next       <= 1'b0;
            rx_byte       <= '0;
            wr_toggle_reg <= 1'b0;
        end else begin
            rd_next       <= 1'b0;
            rx_byte.valid <= 1'b0;
            if (stop_cond) begin
                bus_state_reg <= BUS_IDLE;
                sda_oe        <= 1'b0;
            end else if (start_cond) begin
                bus_state_reg <= BUS_RX;
                bit_cnt_reg   <= 4'h0;
                byte_idx_reg  <= 2'h0;
                read_mode_reg <= 1'b0;
                sda_oe        <= 1'b0;
            end else begin
                case (bus_state_reg)
                    BUS_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    BUS_RX: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_sync_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            if (busy_sync_reg) begin
                                bus_state_reg <= BUS_IGNORE;
                            end else if (byte_idx_reg == 2'h0) begin
                                if (ctrl_match(shift_reg, chip_select_pin_high,
                                               chip_select_pin_low)) begin
                                    sda_oe        <= 1'b1;
                                    bus_state_reg <= BUS_ACK;
                                    read_mode_reg <= shift_reg[`CTRL_DIR_BIT];
                                    byte_idx_reg  <= 2'h1;
                                end else begin
                                    bus_state_reg <= BUS_IGNORE;
                                end
                            end else begin
                                sda_oe          <= 1'b1;
                                bus_state_reg   <= BUS_ACK;
                                rx_byte.valid   <= 1'b1;
                                rx_byte.data    <= shift_reg;
                                rx_byte.is_data <= (byte_idx_reg > 2'(`ADDR_BYTES));
                                if (byte_idx_reg > 2'(`ADDR_BYTES)) begin
                                    wr_toggle_reg <= ~wr_toggle_reg;
                                end else begin
                                    byte_idx_reg <= byte_idx_reg + 2'h1;
                                end
                            end
                        end
                    end
                    BUS_ACK: begin
                        // low is held until scl falls after the ninth pulse
                        if (scl_fall) begin
                            if (read_mode_reg) begin
                                shift_reg     <= {rd_data[6:0], 1'b0};
                                sda_oe        <= ~rd_data[7];
                                rd_next       <= 1'b1;
                                bit_cnt_reg   <= 4'h1;
                                bus_state_reg <= BUS_TX;
                            end else begin
                                sda_oe        <= 1'b0;
                                bus_state_reg <= BUS_RX;
                            end
                        end
                    end
                    BUS_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                sda_oe        <= 1'b0;
                                bus_state_reg <= BUS_MACK;
                            end else begin
                                sda_oe      <= ~shift_reg[7];
                                shift_reg   <= {shift_reg[6:0], 1'b0};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    BUS_MACK: begin
                        if (scl_rise) begin
                            if (sda_sync_reg || busy_sync_reg) begin
                                bus_state_reg <= BUS_IGNORE;
                            end else begin
                                bus_state_reg <= BUS_ACK;
                            end
                        end
                    end
                    BUS_IGNORE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        bus_state_reg <= BUS_IDLE;
                    end
                endcase
            end
        end
    end

    // open drain: the driven level is always low
    assign sda_o = 1'b0;

endmodule

// File: verification/store_recall_monitor.sv
// pin-level checks on the two-wire store/recall slave
// assumes a bind onto two_wire_store_slave; mclk and lclk are unrelated
`timescale 1ns/100ps
module store_recall_monitor #(
    parameter int STORE_CYCLES  = 40,
    parameter int RECALL_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic lclk,
    input wire logic scl_i,
    input wire logic sda_oe,
    input wire logic trip_above_i,
    input wire logic main_above_cap_i,
    input wire logic busy,
    input wire logic vcc_connect
);
    // *****
    // run lengths of levels, counted on mclk
    // *****
    logic [7:0] busy_run_reg;
    logic [7:0] trip_hi_run_reg;
    logic [7:0] trip_lo_run_reg;
    logic [7:0] main_hi_run_reg;

    function automatic logic [7:0] bump(input logic [7:0] v, input logic on);
        return on ? ((v == 8'hff) ? v : v + 8'h01) : 8'h00;
    endfunction

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_run_reg    <= 8'h00;
            trip_hi_run_reg <= 8'h00;
            trip_lo_run_reg <= 8'h00;
            main_hi_run_reg <= 8'h00;
        end else begin
            busy_run_reg    <= bump(busy_run_reg, busy);
            trip_hi_run_reg <= bump(trip_hi_run_reg, trip_above_i);
            trip_lo_run_reg <= bump(trip_lo_run_reg, !trip_above_i);
            main_hi_run_reg <= bump(main_hi_run_reg, main_above_cap_i);
        end
    end

    sequence seq_settled;
        !busy [*3];
    endsequence
    sequence seq_ack_high;
        sda_oe && scl_i;
    endsequence

    AST_NO_ACK_WHILE_BUSY: assert property (
        @(posedge lclk) disable iff (rst) $rose(sda_oe) |-> busy_run_reg < 8'h30)
        else $error("sda pulled low after a long busy spell");
    AST_BUSY_BELOW_TRIP: assert property (
        @(posedge mclk) disable iff (rst) trip_lo_run_reg >= 8'h06 |-> busy)
        else $error("ready while supply below trip");
    AST_RESTORE_LENGTH: assert property (
        @(posedge mclk) disable iff (rst) $fell(busy) |-> int'(busy_run_reg) >= RECALL_CYCLES)
        else $error("busy ended before the restore time");
    AST_READY_BOUND: assert property (
        @(posedge mclk) disable iff (rst)
        int'(trip_hi_run_reg) == STORE_CYCLES + RECALL_CYCLES + 12 |-> !busy)
        else $error("still busy long after supply returned");
    AST_VCC_NEEDS_MAIN: assert property (
        @(posedge mclk) disable iff (rst) $rose(vcc_connect) |-> main_hi_run_reg >= 8'h02)
        else $error("main supply connected while below cap");
    AST_VCC_RETURNS: assert property (
        @(posedge mclk) disable iff (rst)
        seq_settled ##0 (main_hi_run_reg >= 8'h08) |-> vcc_connect)
        else $error("main supply not reconnected when idle");
    AST_ACK_HOLDS: assert property (
        @(posedge lclk) disable iff (rst) seq_ack_high |=> sda_oe || !scl_i)
        else $error("sda released while scl high");
    AST_CHANGE_WHILE_LOW: assert property (
        @(posedge lclk) disable iff (rst) $changed(sda_oe) |-> !scl_i)
        else $error("sda drive changed while scl high");
endmodule

// File: verification/two_wire_master_model.sv
// bus master model: drives scl and pulls sda low, one bus phase per mclk
// assumes the bench resolves the open-drain sda wire and feeds it back
`timescale 1ns/100ps
module two_wire_master_model (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic put_bit(input logic b);
        @(posedge mclk) scl <= 1'b0;
        @(posedge mclk) sda_pull <= ~b;
        @(posedge mclk) scl <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic get_bit(output logic b);
        @(posedge mclk) scl <= 1'b0;
        @(posedge mclk) sda_pull <= 1'b0;
        @(posedge mclk) scl <= 1'b1;
        @(posedge mclk) b = sda;
    endtask

    task automatic start;
        @(posedge mclk) scl <= 1'b0;
        @(posedge mclk) sda_pull <= 1'b0;
        @(posedge mclk) scl <= 1'b1;
        @(posedge mclk) sda_pull <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic stop;
        @(posedge mclk) scl <= 1'b0;
        @(posedge mclk) sda_pull <= 1'b1;
        @(posedge mclk) scl <= 1'b1;
        @(posedge mclk) sda_pull <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(seen);
        ack = !seen;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b[i]);
        end
        put_bit(last);
    endtask
endmodule

// File: verification/two_wire_store_slave_bench.sv
// self-checking bench for the two-wire store/recall slave
// assumes the master model and the pin monitor are compiled before it
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end
module two_wire_store_slave_bench import store_recall_pkg::*;;
    localparam int STORE_N  = 120;
    localparam int RECALL_N = 60;
    logic        mclk, lclk, rst, scl_line, sda_pull, sda_line, sda_o, sda_oe;
    logic        chip_select_pin_low, chip_select_pin_high;
    logic        trip_above_i, main_above_cap_i, rd_next, busy, vcc_connect;
    logic [7:0]  rd_data;
    rx_byte_type rx_byte;
    rx_byte_type rx_q[$];
    int          rd_count = 0;
    int          failures = 0;
    int          tests_run = 0;

    assign sda_line = (sda_oe || sda_pull) ? 1'b0 : 1'b1;
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        lclk = 1'b0;
        #1.3;
        forever #3 lclk = ~lclk;
    end
    always @(negedge lclk) begin
        if (rx_byte.valid === 1'b1) rx_q.push_back(rx_byte);
        if (rd_next === 1'b1) rd_count++;
    end

    two_wire_master_model i_master (.mclk(mclk), .sda(sda_line), .scl(scl_line),
                                    .sda_pull(sda_pull));
    two_wire_store_slave #(.STORE_CYCLES(STORE_N), .RECALL_CYCLES(RECALL_N)) i_dut (
        .mclk(mclk), .rst(rst), .lclk(lclk), .scl_i(scl_line), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_pin_low(chip_select_pin_low),
        .chip_select_pin_high(chip_select_pin_high), .trip_above_i(trip_above_i),
        .main_above_cap_i(main_above_cap_i), .rd_data(rd_data), .rd_next(rd_next),
        .rx_byte(rx_byte), .busy(busy), .vcc_connect(vcc_connect));

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic ctrl(input logic [7:0] b, output logic ack);
        i_master.start();
        i_master.send_byte(b, ack);
    endtask

    task automatic measure_ready(output int n);
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 1000) begin
            failures++;
            complete_run();
        end
    endtask

    task automatic trip_dip(input int low_cycles, output int n);
        @(posedge mclk) trip_above_i <= 1'b0;
        repeat (low_cycles) @(posedge mclk);
        trip_above_i <= 1'b1;
        measure_ready(n);
    endtask

    task automatic power_up_poll;
        logic ack;
        int   tries;
        `CHECK("busy after reset", 1'b1, busy)
        ctrl(8'haa, ack);
        `CHECK("ack below trip", 1'b0, ack)
        i_master.stop();
        @(posedge mclk);
        trip_above_i     <= 1'b1;
        main_above_cap_i <= 1'b1;
        ack   = 1'b0;
        tries = 0;
        while (ack !== 1'b1 && tries < 20) begin
            ctrl(8'haa, ack);
            tries++;
        end
        i_master.stop();
        `CHECK("poll ack", 1'b1, ack)
        `CHECK("nack while restoring", 1'b1, tries > 1)
        `CHECK("vcc connected", 1'b1, vcc_connect)
    endtask

    task automatic write_cmd;
        logic [7:0] bytes[5] = '{8'haa, 8'h12, 8'h34, 8'h5a, 8'hc3};
        logic       ack;
        rx_q.delete();
        i_master.start();
        foreach (bytes[i]) begin
            i_master.send_byte(bytes[i], ack);
            `CHECK("write ack", 1'b1, ack)
        end
        i_master.stop();
        `CHECK("rx count", 32'd4, rx_q.size())
        for (int i = 0; i < 4; i++) begin
            `CHECK("rx kind", i >= 2, rx_q[i].is_data)
            `CHECK("rx byte", bytes[i + 1], rx_q[i].data)
        end
    endtask

    task automatic bad_ctrl;
        logic [7:0] bad[5] = '{8'ha2, 8'hae, 8'ha6, 8'hba, 8'ha8};
        logic       ack;
        foreach (bad[i]) begin
            ctrl(bad[i], ack);
            `CHECK("bad control ack", 1'b0, ack)
            i_master.send_byte(8'h00, ack);
            `CHECK("ack after bad control", 1'b0, ack)
            i_master.stop();
        end
    endtask

    task automatic read_cmd;
        logic       ack;
        logic [7:0] d;
        int         base;
        base = rd_count;
        ctrl(8'hab, ack);
        `CHECK("read control ack", 1'b1, ack)
        i_master.recv_byte(1'b0, d);
        `CHECK("read byte", 8'h5c, d)
        i_master.recv_byte(1'b1, d);
        `CHECK("last read byte", 8'h5c, d)
        i_master.stop();
        `CHECK("released after nack", 1'b0, sda_oe)
        `CHECK("open drain level", 1'b0, sda_o)
        `CHECK("read pulses", 32'd2, rd_count - base)
    endtask

    task automatic store_cycle;
        logic ack;
        int   n;
        @(posedge mclk) trip_above_i <= 1'b0;
        repeat (6) @(negedge mclk);
        `CHECK("vcc cut in store", 1'b0, vcc_connect)
        @(posedge mclk) trip_above_i <= 1'b1;
        ctrl(8'haa, ack);
        i_master.stop();
        `CHECK("ack in store", 1'b0, ack)
        measure_ready(n);
        // under 60 cycles had passed before measuring
        `CHECK("store then restore", 1'b1, n + 60 >= STORE_N + RECALL_N)
        repeat (20) @(negedge mclk);
        `CHECK("vcc back", 1'b1, vcc_connect)
    endtask

    task automatic no_store;
        int n;
        trip_dip(20, n);
        `CHECK("no store when clean", 1'b1, n < STORE_N)
        `CHECK("restore length", 1'b1, n >= RECALL_N)
    endtask

    task automatic restore_abort;
        int n;
        @(posedge mclk) trip_above_i <= 1'b0;
        repeat (20) @(posedge mclk);
        trip_above_i <= 1'b1;
        repeat (20) @(posedge mclk);
        trip_dip(30, n);
        `CHECK("abort skips store", 1'b1, n < STORE_N && n >= RECALL_N)
    endtask

    initial begin
        rst                  = 1'b1;
        trip_above_i         = 1'b0;
        main_above_cap_i     = 1'b0;
        chip_select_pin_low  = 1'b0;
        chip_select_pin_high = 1'b1;
        rd_data              = 8'h5c;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(negedge mclk);
        power_up_poll();
        write_cmd();
        bad_ctrl();
        read_cmd();
        store_cycle();
        no_store();
        restore_abort();
        repeat (10) @(posedge mclk);
        complete_run();
    end
endmodule

bind two_wire_store_slave store_recall_monitor #(
    .STORE_CYCLES(STORE_CYCLES), .RECALL_CYCLES(RECALL_CYCLES)) i_monitor (
    .mclk(mclk), .rst(rst), .lclk(lclk), .scl_i(scl_i), .sda_oe(sda_oe),
    .trip_above_i(trip_above_i), .main_above_cap_i(main_above_cap_i),
    .busy(busy), .vcc_connect(vcc_connect));
